// ---- hdl/serial_irq_pkg.sv ----
// Constants and carrier types for the serial interrupt frame decoder.
// Assumes frame timing counted in cycles of the link clock.
package serial_irq_pkg;
   localparam int NUM_FRAMES  = 21;
   localparam int FRAME_CLKS  = 3;
   localparam int FIRST_SLOT  = 2;
   localparam int LAST_SLOT   = 62;
   localparam int SYNC_LAT    = 2;
   localparam int STOP_BEGIN  = LAST_SLOT + FRAME_CLKS;
   localparam int STOP_QUIET  = 2;
   localparam int STOP_CONT   = 3;
   localparam int START_W0    = 4;
   localparam int START_W1    = 6;
   localparam int START_W2    = 8;
   localparam int IDLE_GAP    = 2;
   // Zero-based frame indices
   localparam int FR_IRQ0     = 0;
   localparam int FR_IRQ1     = 1;
   localparam int FR_SYSMGMT  = 2;
   localparam int FR_IRQ8     = 8;
   localparam int FR_IRQ12    = 12;
   localparam int FR_IRQ13    = 13;
   localparam int FR_IRQ14    = 14;
   localparam int FR_IRQ15    = 15;
   localparam int FR_IOCHK    = 16;
   localparam int FR_PCI_A    = 17;
   localparam logic [20:0] RAW_RESET = 21'h1FFFFF;

   typedef struct packed
   {
      logic [3:0] pirq_n;
      logic       iochk_n;
      logic       sysmgmt_n;
      logic [15:0] isa;
   } frame_levels_t;

   typedef enum {LK_IDLE, LK_START, LK_DATA, LK_STOP, LK_GAP} link_state_t;
endpackage

// ---- hdl/serial_irq_frame_decoder.sv ----
// Serial interrupt stream host: start/stop framing, slot sampling, decode.
// Assumes bus_clock_i is the serial line clock and an external pull-up on the line.
`timescale 1ns/1ps
`default_nettype none
module serial_irq_frame_decoder
   import serial_irq_pkg::*;
(
   input  wire logic        mclk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   input  wire logic        bus_clock_i,
   input  wire logic        serial_enable_i,
   input  wire logic        continuous_mode_i,
   input  wire logic [1:0]  start_width_sel_i,
   input  wire logic        serial_irq_line_i,
   output logic             serial_irq_line_o,
   output logic             serial_irq_line_oe_o,
   input  wire logic        timer0_irq_i,
   input  wire logic        rtc_irq_i,
   input  wire logic        sysmgmt_status_clear_i,
   input  wire logic [3:0]  pci_irq_in_n_i,
   output logic [15:0]      isa_irq_o,
   output logic             system_mgmt_interrupt_n_o,
   output logic             serial_sysmgmt_status_o,
   output logic             io_check_error_n_o,
   output logic             pci_irq_line_a_n_o,
   output logic             pci_irq_line_b_n_o,
   output logic             pci_irq_line_c_n_o,
   output logic             pci_irq_line_d_n_o
);

   // Link-domain synchronisers: reset, enable, config, line
   logic       lrst_s1;
   logic       lrst;
   logic       lce_s1;
   logic       lce;
   logic [3:0] cfg_s1;
   logic [3:0] cfg_s2;
   logic       line_s1;
   logic       line_s2;

   always_ff @(posedge bus_clock_i)
   begin
      lrst_s1 <= rst_i;
      lrst    <= lrst_s1;
      lce_s1  <= ce_i;
      lce     <= lce_s1;
      cfg_s1  <= {serial_enable_i, continuous_mode_i, start_width_sel_i};
      cfg_s2  <= cfg_s1;
      line_s1 <= serial_irq_line_i;
      line_s2 <= line_s1;
   end

   logic       en_s;
   logic       cont_s;
   logic [3:0] start_len;

   always_comb
   begin
      en_s   = cfg_s2[3];
      cont_s = cfg_s2[2];
      case (cfg_s2[1:0])
         2'h1:    start_len = 4'(START_W1);
         2'h2:    start_len = 4'(START_W2);
         default: start_len = 4'(START_W0);
      endcase
   end

   // Link state
   link_state_t l_state;
   link_state_t next_l_state;
   logic [6:0]  l_cnt;
   logic [6:0]  next_l_cnt;
   logic [6:0]  l_smp;
   logic [6:0]  next_l_smp;
   logic [4:0]  l_frame;
   logic [4:0]  next_l_frame;
   logic [3:0]  l_len;
   logic [3:0]  next_l_len;
   logic [20:0] l_raw;
   logic [20:0] next_l_raw;
   logic        l_drv;
   logic        next_l_drv;
   logic        l_oe;
   logic        next_l_oe;
   logic        l_quiet;
   logic        next_l_quiet;
   logic        l_tgl;
   logic        next_l_tgl;

   always_comb
   begin
      next_l_state = l_state;
      next_l_cnt   = l_cnt;
      next_l_smp   = l_smp;
      next_l_frame = l_frame;
      next_l_len   = l_len;
      next_l_raw   = l_raw;
      next_l_drv   = 1'b1;
      next_l_oe    = 1'b0;
      next_l_quiet = l_quiet;
      next_l_tgl   = l_tgl;
      case (l_state)
         LK_IDLE:
         begin
            if (en_s && !l_quiet)
            begin
               next_l_state = LK_START;
               next_l_len   = start_len - 4'h1;
               next_l_drv   = 1'b0;
               next_l_oe    = 1'b1;
            end
            else if (en_s && !line_s2)
            begin
               // Peripheral opened the frame; we finish it one clock shorter
               next_l_state = LK_START;
               next_l_len   = start_len - 4'h2;
               next_l_drv   = 1'b0;
               next_l_oe    = 1'b1;
            end
         end
         LK_START:
         begin
            next_l_oe = 1'b1;
            if (l_len != 4'h0)
            begin
               next_l_len = l_len - 4'h1;
               next_l_drv = 1'b0;
            end
            else
            begin
               // Recovery high before release, count frames from here
               next_l_state = LK_DATA;
               next_l_cnt   = 7'h00;
               next_l_smp   = 7'(FIRST_SLOT + SYNC_LAT);
               next_l_frame = 5'h00;
            end
         end
         LK_DATA:
         begin
            next_l_cnt = l_cnt + 7'h01;
            // Pin synchroniser adds a fixed lag to every slot
            if (l_cnt == l_smp && l_frame < 5'(NUM_FRAMES))
            begin
               next_l_raw[l_frame] = line_s2;
               next_l_frame        = l_frame + 5'h01;
               next_l_smp          = l_smp + 7'(FRAME_CLKS);
            end
            if (l_cnt == 7'(STOP_BEGIN - 1))
            begin
               next_l_state = LK_STOP;
               next_l_len   = cont_s ? 4'(STOP_CONT - 1) : 4'(STOP_QUIET - 1);
               next_l_quiet = !cont_s;
               next_l_drv   = 1'b0;
               next_l_oe    = 1'b1;
               next_l_tgl   = !l_tgl;
            end
         end
         LK_STOP:
         begin
            next_l_oe = 1'b1;
            if (l_len != 4'h0)
            begin
               next_l_len = l_len - 4'h1;
               next_l_drv = 1'b0;
            end
            else
            begin
               next_l_state = LK_GAP;
               next_l_len   = 4'(IDLE_GAP);
            end
         end
         LK_GAP:
         begin
            if (l_len != 4'h0)
               next_l_len = l_len - 4'h1;
            else
               next_l_state = LK_IDLE;
         end
         default:
            next_l_state = LK_IDLE;
      endcase
   end

   always_ff @(posedge bus_clock_i)
   begin
      if (lrst)
      begin
         l_state <= LK_IDLE;
         l_cnt   <= 7'h00;
         l_smp   <= 7'h00;
         l_frame <= 5'h00;
         l_len   <= 4'h0;
         l_raw   <= RAW_RESET;
         l_drv   <= 1'b1;
         l_oe    <= 1'b0;
         l_quiet <= 1'b0;
         l_tgl   <= 1'b0;
      end
      else if (lce)
      begin
         l_state <= next_l_state;
         l_cnt   <= next_l_cnt;
         l_smp   <= next_l_smp;
         l_frame <= next_l_frame;
         l_len   <= next_l_len;
         l_raw   <= next_l_raw;
         l_drv   <= next_l_drv;
         l_oe    <= next_l_oe;
         l_quiet <= next_l_quiet;
         l_tgl   <= next_l_tgl;
      end
   end

   assign serial_irq_line_o    = l_drv;
   assign serial_irq_line_oe_o = l_oe;

   // System domain: toggle crossing; l_raw is quiet long after the toggle
   logic       tgl_s1;
   logic       tgl_s2;
   logic       tgl_s3;
   logic [3:0] pci_s1;
   logic [3:0] pci_s2;

   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         tgl_s1 <= 1'b0;
         tgl_s2 <= 1'b0;
         tgl_s3 <= 1'b0;
         pci_s1 <= 4'hF;
         pci_s2 <= 4'hF;
      end
      else if (ce_i)
      begin
         tgl_s1 <= l_tgl;
         tgl_s2 <= tgl_s1;
         tgl_s3 <= tgl_s2;
         pci_s1 <= pci_irq_in_n_i;
         pci_s2 <= pci_s1;
      end
   end

   frame_levels_t lv;
   frame_levels_t next_lv;
   logic          sts;
   logic          next_sts;
   logic [3:0]    pci_out_n;
   logic [3:0]    next_pci_out_n;
   logic          new_frame;

   always_comb
   begin
      new_frame = tgl_s2 ^ tgl_s3;
      next_lv   = lv;
      if (new_frame)
      begin
         // Low means not requested on ISA slots, so level follows the line
         next_lv.isa = l_raw[15:0];
         next_lv.isa[0]  = 1'b0;
         // Slot 2 is the system request, so no frame carries interrupt 2
         next_lv.isa[2]  = 1'b0;
         next_lv.isa[8]  = 1'b0;
         next_lv.isa[13] = 1'b0;
         next_lv.sysmgmt_n = l_raw[FR_SYSMGMT];
         next_lv.iochk_n   = l_raw[FR_IOCHK];
         next_lv.pirq_n    = l_raw[FR_PCI_A +: 4];
      end
      // Clearing loses to a fresh event
      next_sts = (sts && !sysmgmt_status_clear_i) || (new_frame && !l_raw[FR_SYSMGMT]);
      next_pci_out_n = next_lv.pirq_n & pci_s2;
   end

   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         lv.isa       <= 16'h0000;
         lv.sysmgmt_n <= 1'b1;
         lv.iochk_n   <= 1'b1;
         lv.pirq_n    <= 4'hF;
         sts          <= 1'b0;
         pci_out_n    <= 4'hF;
         isa_irq_o    <= 16'h0000;
      end
      else if (ce_i)
      begin
         lv        <= next_lv;
         sts       <= next_sts;
         pci_out_n <= next_pci_out_n;
         // Slot levels for 0, 8, 13 are discarded; timer0 and rtc own 0 and 8, 13 stays low
         isa_irq_o <= {next_lv.isa[15:9], rtc_irq_i, next_lv.isa[7:1], timer0_irq_i};
      end
   end

   assign system_mgmt_interrupt_n_o = lv.sysmgmt_n;
   assign serial_sysmgmt_status_o   = sts;
   assign io_check_error_n_o        = lv.iochk_n;
   assign pci_irq_line_a_n_o        = pci_out_n[0];
   assign pci_irq_line_b_n_o        = pci_out_n[1];
   assign pci_irq_line_c_n_o        = pci_out_n[2];
   assign pci_irq_line_d_n_o        = pci_out_n[3];

endmodule
`default_nettype wire

// ---- testbench/serial_irq_asserts.sv ----
// Port checker for the serial interrupt frame decoder.
// Assumes a bind from the bench top; c mirrors the frame clock count.
`timescale 1ns/1ps
`default_nettype none
module serial_irq_asserts
(
   input wire logic        mclk_i,
   input wire logic        rst_i,
   input wire logic        bus_clock_i,
   input wire logic        continuous_mode_i,
   input wire logic        timer0_irq_i,
   input wire logic        sysmgmt_status_clear_i,
   input wire logic [3:0]  pci_irq_in_n_i,
   input wire logic        serial_irq_line_i,
   input wire logic        serial_irq_line_o,
   input wire logic        serial_irq_line_oe_o,
   input wire logic [15:0] isa_irq_o,
   input wire logic        system_mgmt_interrupt_n_o,
   input wire logic        serial_sysmgmt_status_o,
   input wire logic        pci_irq_line_a_n_o
);
   logic [6:0] c;
   logic [6:0] next_c;
   logic       was_lo;
   logic       lo;
   logic       hi;
   assign lo = serial_irq_line_oe_o && !serial_irq_line_o;
   assign hi = serial_irq_line_oe_o && serial_irq_line_o;
   // Runs past the stop frame so its release edge is not taken for a start
   always_comb
   begin
      next_c = c;
      if (c != 7'h00)
         next_c = (c == 7'h48) ? 7'h00 : c + 7'h01;
      else if (was_lo && hi)
         next_c = 7'h01;
   end
   always_ff @(posedge bus_clock_i)
   begin
      c      <= rst_i ? 7'h00 : next_c;
      was_lo <= lo;
   end
   a_high_then_release: assert property (@(posedge bus_clock_i) disable iff (rst_i)
      was_lo && hi |=> !serial_irq_line_oe_o) else $error("line not released");
   a_frames_undriven: assert property (@(posedge bus_clock_i) disable iff (rst_i)
      c >= 7'h01 && c <= 7'h40 |-> !serial_irq_line_oe_o) else $error("drive in slot");
   a_stop_cont: assert property (@(posedge bus_clock_i) disable iff (rst_i)
      c == 7'h41 && continuous_mode_i |-> lo ##1 lo ##1 lo ##1 hi) else $error("stop not 3");
   a_stop_quiet: assert property (@(posedge bus_clock_i) disable iff (rst_i)
      c == 7'h41 && !continuous_mode_i |-> lo ##1 lo ##1 hi) else $error("stop not 2");
   a_irq13_quiet: assert property (@(posedge mclk_i) disable iff (rst_i)
      isa_irq_o[13] == 1'b0) else $error("irq13 set");
   a_timer_path: assert property (@(posedge mclk_i) disable iff (rst_i)
      !$past(rst_i) |-> isa_irq_o[0] == $past(timer0_irq_i)) else $error("irq0 path");
   a_pci_and: assert property (@(posedge mclk_i) disable iff (rst_i)
      $fell(pci_irq_in_n_i[0]) |-> ##[1:4] !pci_irq_line_a_n_o) else $error("pci a");
   a_smi_status: assert property (@(posedge mclk_i) disable iff (rst_i)
      $fell(system_mgmt_interrupt_n_o) |-> serial_sysmgmt_status_o) else $error("no status");
   a_status_sticky: assert property (@(posedge mclk_i) disable iff (rst_i)
      serial_sysmgmt_status_o && !sysmgmt_status_clear_i |=> serial_sysmgmt_status_o)
      else $error("status lost");
   c_stop_cont: cover property (@(posedge bus_clock_i) c == 7'h41 && continuous_mode_i);
   c_stop_quiet: cover property (@(posedge bus_clock_i) c == 7'h41 && !continuous_mode_i);
   c_smi: cover property (@(posedge mclk_i) $fell(system_mgmt_interrupt_n_o));
   c_quiet_start: cover property (@(posedge bus_clock_i)
      c == 7'h00 && !continuous_mode_i && !serial_irq_line_oe_o && !serial_irq_line_i);
endmodule
`default_nettype wire

// ---- testbench/serial_irq_peripheral.sv ----
// Shared peripheral model on the serial interrupt line.
// Assumes the bench resolves the wire with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module serial_irq_peripheral
(
   input wire logic        bus_clock_i,
   input wire logic        dev_o_i,
   input wire logic        dev_oe_i,
   input wire logic        start_req_i,
   input wire logic [20:0] pattern_i,
   output logic            drive_o,
   output logic            drive_oe_o
);
   int          c = 0;
   int          s;
   logic        was_lo;
   logic        kick = 1'b0;
   logic [20:0] pat;
   always @(posedge bus_clock_i)
   begin
      was_lo <= dev_oe_i && !dev_o_i;
      // Quiet mode: hold low until the host takes the start over
      kick   <= start_req_i && c == 0 && !dev_oe_i;
      if (c != 0)
         c <= (c == 72) ? 0 : c + 1;
      else if (was_lo && dev_oe_i && dev_o_i)
      begin
         c   <= 1;
         pat <= pattern_i;
      end
   end
   // Low in sample, high in recovery, released in turn-around
   always_comb
   begin
      s          = (c - 2) / 3;
      drive_oe_o = kick || (c >= 2 && s < 21 && pat[s] && (c - 2) % 3 != 2);
      drive_o    = !kick && (c - 2) % 3 == 1;
   end
endmodule
`default_nettype wire

// ---- testbench/testbench.sv ----
// Bench for the serial interrupt frame decoder with one peripheral model.
// Assumes the checker is bound to the decoder below.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic        mclk_i = 1'b0;
   logic        bus_clock_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        serial_enable_i = 1'b0;
   logic        continuous_mode_i = 1'b1;
   logic [1:0]  start_width_sel_i = 2'h0;
   logic        timer0_irq_i = 1'b0;
   logic        rtc_irq_i = 1'b0;
   logic        sysmgmt_status_clear_i = 1'b0;
   logic [3:0]  pci_irq_in_n_i = 4'hF;
   logic [20:0] pat = 21'h000000;
   logic        start_req = 1'b0;
   logic        serial_irq_line_o;
   logic        serial_irq_line_oe_o;
   logic        p_o;
   logic        p_oe;
   logic        system_mgmt_interrupt_n_o;
   logic        serial_sysmgmt_status_o;
   logic        io_check_error_n_o;
   logic [3:0]  pci_o_n;
   logic [15:0] isa_irq_o;
   wire         serial_irq_line_i = serial_irq_line_oe_o ? serial_irq_line_o : (p_oe ? p_o : 1'b1);
   int          failures = 0;
   int          comparisons = 0;
   always #12.5 mclk_i = ~mclk_i;
   initial
   begin
      #7;
      forever #62.5 bus_clock_i = ~bus_clock_i;
   end
   serial_irq_frame_decoder serial_irq_frame_decoder_inst (.mclk_i, .rst_i, .ce_i(1'b1), .bus_clock_i,
      .serial_enable_i, .continuous_mode_i, .start_width_sel_i, .serial_irq_line_i, .serial_irq_line_o,
      .serial_irq_line_oe_o, .timer0_irq_i, .rtc_irq_i, .sysmgmt_status_clear_i, .pci_irq_in_n_i,
      .isa_irq_o, .system_mgmt_interrupt_n_o, .serial_sysmgmt_status_o, .io_check_error_n_o,
      .pci_irq_line_a_n_o(pci_o_n[0]), .pci_irq_line_b_n_o(pci_o_n[1]),
      .pci_irq_line_c_n_o(pci_o_n[2]), .pci_irq_line_d_n_o(pci_o_n[3]));
   serial_irq_peripheral serial_irq_peripheral_inst (.bus_clock_i, .dev_o_i(serial_irq_line_o),
      .dev_oe_i(serial_irq_line_oe_o), .start_req_i(start_req), .pattern_i(pat), .drive_o(p_o),
      .drive_oe_o(p_oe));
   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
      comparisons++;
      if (got !== exp)
      begin
         failures++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   // Four falls of the drive enable span one whole frame sent with p
   task automatic frame_case(input logic [20:0] p, input logic [3:0] pin, input logic t,
                             input logic r, input logic [1:0] w, input logic clr, input logic es);
      @(posedge mclk_i);
      pat                    <= p;
      pci_irq_in_n_i         <= pin;
      timer0_irq_i           <= t;
      rtc_irq_i              <= r;
      start_width_sel_i      <= w;
      sysmgmt_status_clear_i <= clr;
      repeat (4) @(negedge serial_irq_line_oe_o);
      repeat (8) @(posedge mclk_i);
      check(isa_irq_o & 16'hDEFA, ~p[15:0] & 16'hDEFA, "isa");
      check({12'h000, isa_irq_o[13], isa_irq_o[8], isa_irq_o[2], isa_irq_o[0]},
            {12'h000, 1'b0, r, 1'b0, t}, "fixed");
      check({10'h000, system_mgmt_interrupt_n_o, io_check_error_n_o, pci_o_n},
            {10'h000, ~p[2], ~p[16], ~p[20:17] & pin}, "ctl");
      check({15'h0000, serial_sysmgmt_status_o}, {15'h0000, es}, "status");
      sysmgmt_status_clear_i <= 1'b0;
   endtask
   task automatic quiet_case;
      int n;
      n = 0;
      @(posedge mclk_i);
      continuous_mode_i <= 1'b0;
      repeat (200) @(posedge bus_clock_i);
      repeat (100) @(posedge bus_clock_i) n += serial_irq_line_oe_o ? 1 : 0;
      check(16'(n), 16'h0000, "quiet start");
   endtask
   // Quiet mode: the peripheral opens the start, the host completes it
   task automatic quiet_start_case(input logic [20:0] p);
      @(posedge mclk_i);
      pat       <= p;
      start_req <= 1'b1;
      @(posedge serial_irq_line_oe_o);
      @(posedge mclk_i);
      start_req <= 1'b0;
      repeat (2) @(negedge serial_irq_line_oe_o);
      repeat (8) @(posedge mclk_i);
      check(isa_irq_o & 16'hDEFA, ~p[15:0] & 16'hDEFA, "quiet isa");
      check({14'h0000, system_mgmt_interrupt_n_o, io_check_error_n_o},
            {14'h0000, ~p[2], ~p[16]}, "quiet ctl");
   endtask
   task automatic conclude;
      if (failures == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial
   begin
      #400us;
      failures++;
      conclude;
   end
   initial
   begin
      repeat (16) @(posedge mclk_i);
      rst_i           <= 1'b0;
      serial_enable_i <= 1'b1;
      frame_case(21'h000000, 4'hF, 1'b1, 1'b0, 2'h0, 1'b0, 1'b0);
      frame_case(21'h1FFFFF, 4'hF, 1'b0, 1'b1, 2'h1, 1'b0, 1'b1);
      frame_case(21'h0AAAAA, 4'h5, 1'b1, 1'b1, 2'h2, 1'b0, 1'b1);
      frame_case(21'h155551, 4'hA, 1'b0, 1'b0, 2'h3, 1'b1, 1'b0);
      quiet_case;
      quiet_start_case(21'h0F0F0F);
      conclude;
   end
endmodule
bind serial_irq_frame_decoder serial_irq_asserts serial_irq_asserts_inst (.mclk_i, .rst_i, .bus_clock_i,
   .continuous_mode_i, .timer0_irq_i, .sysmgmt_status_clear_i, .pci_irq_in_n_i, .serial_irq_line_i,
   .serial_irq_line_o,
   .serial_irq_line_oe_o, .isa_irq_o, .system_mgmt_interrupt_n_o, .serial_sysmgmt_status_o,
   .pci_irq_line_a_n_o);
`default_nettype wire
